/* test_task_priority_scheduler.sv */
// self-checking testbench of the task priority scheduler
`timescale 1ns/1ps
`default_nettype none
module test_task_priority_scheduler import tps_pkg::*; ();
	// ****************************************
	// stimulus and checking
	// ****************************************
	logic ref_clk_i, reset_n_i = 0, cfg_we_i = 0, cfg_used_i = 0;
	logic mode_run_i = 0, power_fail_i = 0, init_busy_i = 0, scan_end_i = 0;
	logic blk = 0, alw = 0, task_done_i = 0;
	logic [6:0] cfg_task_i = 0;
	logic [2:0] cfg_prio_i = 0;
	logic [31:0] cfg_period_i = 0, dev_cond_i = 0;
	logic run_vld_o, run_start_o, scan_run_o, run_allowed_o;
	logic [6:0] run_task_o;
	logic [63:0] pending_o;
	logic [15:0] t_max, t_min, t_cur;
	logic [6:0] exp_q[$];
	int miscompares = 0, samples_checked = 0, cycles = 0;
	int busy_len = 4, busy_cnt = 0, i, k;

	tps_top #(.TICK_CYC(10), .TENTH_CYC(4)) DUT (.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i), .cfg_we_i(cfg_we_i), .cfg_task_i(cfg_task_i),
		.cfg_used_i(cfg_used_i), .cfg_prio_i(cfg_prio_i),
		.cfg_period_i(cfg_period_i), .mode_run_i(mode_run_i),
		.power_fail_i(power_fail_i), .init_busy_i(init_busy_i),
		.task_run_block_cmd_i(blk), .task_run_allow_cmd_i(alw),
		.scan_end_i(scan_end_i), .task_done_i(task_done_i),
		.dev_cond_i(dev_cond_i), .run_vld_o(run_vld_o),
		.run_task_o(run_task_o), .run_start_o(run_start_o),
		.scan_run_o(scan_run_o), .run_allowed_o(run_allowed_o),
		.pending_o(pending_o), .cyc_time_max_o(t_max),
		.cyc_time_min_o(t_min), .cyc_time_cur_o(t_cur));

	initial begin
		ref_clk_i = 0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	task print_verdict();
		if (miscompares == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	task check_val(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val

	task check_grant(input logic [6:0] got, input logic [6:0] exp);
		check_val({57'h0, got}, {57'h0, exp});
	endtask : check_grant

	task tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : tick

	task cfg(input logic [6:0] t, input logic u, input logic [2:0] p,
		input logic [31:0] per);
		@(posedge ref_clk_i);
		cfg_we_i <= 1;
		cfg_task_i <= t;
		cfg_used_i <= u;
		cfg_prio_i <= p;
		cfg_period_i <= per;
		@(posedge ref_clk_i);
		cfg_we_i <= 0;
	endtask : cfg

	// 0 scan end, 1 block, 2 allow
	task cmd(input int c);
		@(posedge ref_clk_i);
		scan_end_i <= (c == 0);
		blk <= (c == 1);
		alw <= (c == 2);
		@(posedge ref_clk_i);
		scan_end_i <= 0;
		blk <= 0;
		alw <= 0;
	endtask : cmd

	task wait_idle();
		for (k = 0; k < 600; k++) begin
			if (run_vld_o === 1'b0 && exp_q.size() == 0)
				break;
			@(posedge ref_clk_i);
		end
		check_val(exp_q.size(), 0);
	endtask : wait_idle

	// every fresh start is matched against the oldest note
	always @(posedge ref_clk_i) begin
		if (run_start_o === 1'b1) begin
			if (exp_q.size() == 0)
				check_grant(run_task_o, 7'h7f);
			else
				check_grant(run_task_o, exp_q.pop_front());
		end
	end

	// far side raises done on the busy_len+1th granted cycle
	always @(posedge ref_clk_i) begin
		task_done_i <= 1'b0;
		if (run_vld_o === 1'b1 && !task_done_i) begin
			if (busy_cnt >= busy_len) begin
				task_done_i <= 1'b1;
				busy_cnt <= 0;
			end else
				busy_cnt <= busy_cnt + 1;
		end
	end

	// hang guard, the whole run needs well under this
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	initial begin
		void'($urandom(67));
		tick(3);
		reset_n_i <= 1;
		tick(3);
		check_val(t_min, TPS_TMIN_RST);
		check_val(run_allowed_o, 0);
		mode_run_i <= 1;
		cfg(7'h40, 1, 3'h5, 0);
		cfg(7'h41, 1, 3'h5, 0);
		cfg(7'h42, 1, 3'h3, 0);
		cfg(7'h43, 1, 3'h0, 0);
		dev_cond_i <= 32'hf;
		cmd(0);
		dev_cond_i <= 0;
		tick(20);
		check_val(pending_o, 64'h7_0000_0000);
		check_val(scan_run_o, 0);
		exp_q = '{7'h42, 7'h40, 7'h41};
		cmd(2);
		wait_idle();
		check_val(scan_run_o, 1);
		// older request wins a tie, init and block hold starts
		cmd(1);
		dev_cond_i <= 32'h2;
		cmd(0);
		dev_cond_i <= 32'h1;
		tick(5);
		cmd(0);
		dev_cond_i <= 0;
		init_busy_i <= 1;
		cmd(2);
		tick(20);
		check_val(pending_o, 64'h3_0000_0000);
		exp_q = '{7'h41, 7'h40};
		init_busy_i <= 0;
		wait_idle();
		// condition gone before the scan end is missed
		dev_cond_i <= $urandom() | 32'h1;
		tick(3);
		dev_cond_i <= 0;
		tick(2);
		cmd(0);
		tick(20);
		check_val(pending_o, 0);
		// repeated expiries while pending collapse into one run
		cmd(1);
		cfg(7'h00, 1, 3'h2, 1);
		tick(60);
		check_val(pending_o, 64'h1);
		mode_run_i <= 0;
		exp_q = '{7'h00};
		cmd(2);
		tick(100);
		wait_idle();
		tick(10);
		check_val(t_min, t_max);
		check_val(t_cur, t_max);
		check_val(t_min === TPS_TMIN_RST, 0);
		// urgent cyclic request preempts a device task
		cfg(7'h00, 1, 3'h2, 3);
		busy_len = 60;
		mode_run_i <= 1;
		exp_q = '{7'h40, 7'h00};
		dev_cond_i <= 32'h1;
		cmd(0);
		dev_cond_i <= 0;
		for (i = 0; i < 100 && run_task_o !== 7'h40; i++)
			tick(1);
		for (i = 0; i < 100 && run_task_o !== 7'h00; i++)
			tick(1);
		mode_run_i <= 0;
		for (i = 0; i < 200 && run_task_o === 7'h00; i++)
			tick(1);
		check_grant(run_task_o, 7'h40);
		check_val(run_vld_o, 1);
		wait_idle();
		busy_len = 4;
		cfg(7'h00, 0, 3'h2, 0);
		mode_run_i <= 1;
		// long then short power interruption
		for (i = 0; i < 2; i++) begin
			cmd(1);
			dev_cond_i <= 32'h1;
			cmd(0);
			dev_cond_i <= 0;
			power_fail_i <= 1;
			tick(i ? 100 : 300);
			power_fail_i <= 0;
			tick(10);
			check_val(pending_o, i ? 64'h1_0000_0000 : 0);
			if (i)
				exp_q = '{7'h40};
			cmd(2);
			wait_idle();
		end
		print_verdict();
	end
endmodule : test_task_priority_scheduler
`default_nettype wire

/* tps_cyc_timer.sv */
// fixed-cycle interval timer bank, one millisecond counter per task
`timescale 1ns/1ps
`default_nettype none
module tps_cyc_timer import tps_pkg::*; #(
	parameter int unsigned N = TPS_NUM_FIX
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// scheduler side
	tps_tmr_if.timer tmr
);

	logic [31:0] period_q [N];
	logic [31:0] cnt_q [N];
	logic [N-1:0] used_q;
	logic [N-1:0] expire_q;

	assign tmr.expire = expire_q;

	// ************************************************
	// counters
	// ************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < N; i++) begin
				period_q[i] <= TPS_PERIOD_RST;
				cnt_q[i] <= 32'h0000_0000;
			end
			used_q <= '0;
			expire_q <= '0;
		end else begin
			expire_q <= '0;
			for (int i = 0; i < N; i++) begin
				if (tmr.cfg_we && tmr.cfg_idx == 5'(i)) begin
					period_q[i] <= tmr.cfg_period;
					used_q[i] <= tmr.cfg_used;
					cnt_q[i] <= 32'h0000_0000;
				// only counts in run mode with power good
				end else if (tmr.ms_tick && tmr.count_en && used_q[i] &&
					period_q[i] != 32'h0000_0000) begin
					// full 32-bit millisecond range
					if (cnt_q[i] + 32'h0000_0001 >= period_q[i]) begin
						cnt_q[i] <= 32'h0000_0000;
						expire_q[i] <= 1'b1;
					end else begin
						cnt_q[i] <= cnt_q[i] + 32'h0000_0001;
					end
				end
			end
		end
	end

endmodule : tps_cyc_timer
`default_nettype wire

/* tps_pkg.sv */
// package: constants and types of the task priority scheduler
package tps_pkg;

	// ************************************************
	// task population
	// ************************************************
	localparam int unsigned TPS_NUM_FIX = 32;
	localparam int unsigned TPS_NUM_DEV = 32;
	localparam int unsigned TPS_NUM_TASK = TPS_NUM_FIX + TPS_NUM_DEV;
	localparam logic [6:0] TPS_FIX_NUM_BASE = 7'h00;
	localparam logic [6:0] TPS_DEV_NUM_BASE = 7'h40;

	// ************************************************
	// priority levels, lower value is more urgent
	// ************************************************
	localparam logic [2:0] TPS_PRIO_MIN = 3'h2;
	localparam logic [2:0] TPS_PRIO_MAX = 3'h7;
	localparam logic [2:0] TPS_PRIO_RST = 3'h7;

	// ************************************************
	// timing
	// ************************************************
	localparam int unsigned TPS_CLK_MHZ = 125;
	localparam int unsigned TPS_TICK_US = 1000;
	localparam int unsigned TPS_TICK_CYC = TPS_CLK_MHZ * TPS_TICK_US;
	localparam int unsigned TPS_TENTH_US = 100;
	localparam int unsigned TPS_TENTH_CYC = TPS_CLK_MHZ * TPS_TENTH_US;
	localparam logic [4:0] TPS_SHORT_INTR_MS = 5'h14;

	// ************************************************
	// reset values
	// ************************************************
	localparam logic [15:0] TPS_TMIN_RST = 16'hffff;
	localparam logic [15:0] TPS_TMAX_RST = 16'h0000;
	localparam logic [31:0] TPS_PERIOD_RST = 32'h0000_0000;

	typedef logic [TPS_NUM_TASK-1:0] tps_vec_t;

	// arbitration key, smaller wins: prio, resumed first, age, creation
	typedef struct packed {
		logic [2:0] prio;
		logic fresh;
		logic [15:0] stamp;
		logic [5:0] seq;
	} tps_key_t;

endpackage : tps_pkg

/* tps_tmr_if.sv */
// interface: scheduler to fixed-cycle interval timer bank
`timescale 1ns/1ps
`default_nettype none
interface tps_tmr_if #(parameter int unsigned N = 32);
	logic ms_tick;
	logic count_en;
	logic cfg_we;
	logic [4:0] cfg_idx;
	logic cfg_used;
	logic [31:0] cfg_period;
	logic [N-1:0] expire;

	modport sched (output ms_tick, count_en, cfg_we, cfg_idx, cfg_used,
		cfg_period, input expire);
	modport timer (input ms_tick, count_en, cfg_we, cfg_idx, cfg_used,
		cfg_period, output expire);
endinterface : tps_tmr_if
`default_nettype wire

/* tps_top.sv */
// task priority scheduler: arbitration of scan, cyclic and device tasks
// Summary of operation
// - highest priority pending task is granted first
// - equal priority served oldest request first
// - equal priority, same time: creation order decides
// - no user task starts during initialization
// - any task suspends scan; scan resumes afterward
// - block command holds starts until allow command
// - initialization ignores block and allow commands
// - cyclic request dropped while running or pending
// - interval timers count only in run, power good
// - max, min, current cyclic task time kept
// - device conditions sampled at scan end only
// - condition pulsing within one scan is missed
// - long interruption discards every pending request
// - short interruption keeps pending tasks
// - urgent cyclic request preempts device task
// - priority levels 2 to 7, 2 most urgent
// - periods in 1 ms steps, 32-bit counter
// - 32 cyclic tasks 0-31, 32 device 64-95
// - all tasks blocked right after power-on
`timescale 1ns/1ps
`default_nettype none
module tps_top import tps_pkg::*; #(
	parameter int unsigned TICK_CYC = TPS_TICK_CYC,
	parameter int unsigned TENTH_CYC = TPS_TENTH_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// task configuration
	input wire logic cfg_we_i,
	input wire logic [6:0] cfg_task_i,
	input wire logic cfg_used_i,
	input wire logic [2:0] cfg_prio_i,
	input wire logic [31:0] cfg_period_i,
	// cpu state and commands
	input wire logic mode_run_i,
	input wire logic power_fail_i,
	input wire logic init_busy_i,
	input wire logic task_run_block_cmd_i,
	input wire logic task_run_allow_cmd_i,
	input wire logic scan_end_i,
	input wire logic task_done_i,
	input wire logic [TPS_NUM_DEV-1:0] dev_cond_i,
	// grant
	output logic run_vld_o,
	output logic [6:0] run_task_o,
	output logic run_start_o,
	output logic scan_run_o,
	output logic run_allowed_o,
	output logic [TPS_NUM_TASK-1:0] pending_o,
	// cyclic task execution time, 0.1 ms units
	output logic [15:0] cyc_time_max_o,
	output logic [15:0] cyc_time_min_o,
	output logic [15:0] cyc_time_cur_o
);

	// ************************************************
	// helpers
	// ************************************************
	function automatic logic [6:0] tps_idx_to_num(input logic [5:0] idx);
		return idx[5] ? (TPS_DEV_NUM_BASE | {2'b00, idx[4:0]}) :
			(TPS_FIX_NUM_BASE | {2'b00, idx[4:0]});
	endfunction : tps_idx_to_num

	// only numbers 0-31 and 64-95 map to a task
	function automatic logic tps_num_ok(input logic [6:0] num);
		return (num[6:5] == TPS_FIX_NUM_BASE[6:5]) ||
			(num[6:5] == TPS_DEV_NUM_BASE[6:5]);
	endfunction : tps_num_ok

	// ************************************************
	// reset release and pin synchroniser
	// ************************************************
	logic rst_s1_q, rst_n;
	logic pf_s1_q, pf_q;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pf_s1_q <= 1'b0;
			pf_q <= 1'b0;
		end else begin
			pf_s1_q <= power_fail_i;
			pf_q <= pf_s1_q;
		end
	end

	// ************************************************
	// configuration store
	// ************************************************
	logic [2:0] prio_q [TPS_NUM_TASK];
	logic [5:0] seq_q [TPS_NUM_TASK];
	tps_vec_t used_q;
	logic [5:0] seq_cnt_q;
	logic [5:0] cfg_idx;
	logic cfg_ok;

	assign cfg_idx = {cfg_task_i[6], cfg_task_i[4:0]};
	// out-of-range number or level is refused
	assign cfg_ok = cfg_we_i && tps_num_ok(cfg_task_i) &&
		cfg_prio_i >= TPS_PRIO_MIN && cfg_prio_i <= TPS_PRIO_MAX;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < TPS_NUM_TASK; i++) begin
				prio_q[i] <= TPS_PRIO_RST;
				seq_q[i] <= 6'h00;
			end
			used_q <= '0;
			seq_cnt_q <= 6'h00;
		end else if (cfg_ok) begin
			prio_q[cfg_idx] <= cfg_prio_i;
			used_q[cfg_idx] <= cfg_used_i;
			// creation sequence breaks ties left after level and age
			seq_q[cfg_idx] <= seq_cnt_q;
			seq_cnt_q <= seq_cnt_q + 6'h01;
		end
	end

	// ************************************************
	// millisecond tick and timer bank
	// ************************************************
	logic [31:0] tick_cnt_q;
	logic ms_tick;
	logic count_en;

	assign ms_tick = (tick_cnt_q == 32'(TICK_CYC - 1));
	assign count_en = mode_run_i && !pf_q;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= 32'h0000_0000;
		end else begin
			tick_cnt_q <= ms_tick ? 32'h0000_0000 :
				tick_cnt_q + 32'h0000_0001;
		end
	end

	tps_tmr_if #(.N(TPS_NUM_FIX)) tmr ();

	assign tmr.ms_tick = ms_tick;
	assign tmr.count_en = count_en;
	assign tmr.cfg_we = cfg_ok && !cfg_task_i[6];
	assign tmr.cfg_idx = cfg_task_i[4:0];
	assign tmr.cfg_used = cfg_used_i;
	assign tmr.cfg_period = cfg_period_i;

	tps_cyc_timer #(.N(TPS_NUM_FIX)) u_timer (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.tmr(tmr)
	);

	// ************************************************
	// power interruption length
	// ************************************************
	logic [4:0] intr_ms_q;
	logic pf_d1_q;
	logic long_resume;

	assign long_resume = pf_d1_q && !pf_q && intr_ms_q > TPS_SHORT_INTR_MS;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			intr_ms_q <= 5'h00;
			pf_d1_q <= 1'b0;
		end else begin
			pf_d1_q <= pf_q;
			if (!pf_q) begin
				intr_ms_q <= 5'h00;
			end else if (ms_tick && intr_ms_q <= TPS_SHORT_INTR_MS) begin
				intr_ms_q <= intr_ms_q + 5'h01;
			end
		end
	end

	// ************************************************
	// block and allow commands
	// ************************************************
	logic allow_q;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			allow_q <= 1'b0;
		end else if (task_run_block_cmd_i) begin
			allow_q <= 1'b0;
		end else if (task_run_allow_cmd_i) begin
			allow_q <= 1'b1;
		end
	end

	// ************************************************
	// arbitration
	// ************************************************
	tps_vec_t pend_q, started_q;
	logic [15:0] stamp_q [TPS_NUM_TASK];
	logic [15:0] age_cnt_q;
	logic cur_vld_q;
	logic [5:0] cur_q;
	logic start_q;
	logic may_start;
	tps_vec_t cand;
	logic best_vld;
	logic [5:0] best_idx;
	tps_key_t best_key;
	tps_key_t key;

	// init task is outside this arbiter; the block command never gates it
	assign may_start = allow_q && !init_busy_i && !pf_q &&
		!long_resume; // no fresh start before a discard lands

	always_comb begin
		key = '0;
		best_vld = 1'b0;
		best_idx = 6'h00;
		best_key = '1;
		for (int i = 0; i < TPS_NUM_TASK; i++) begin
			cand[i] = (pend_q[i] && may_start) ||
				(started_q[i] && !(cur_vld_q && cur_q == 6'(i)));
			key = '{prio: prio_q[i], fresh: !started_q[i],
				stamp: stamp_q[i], seq: seq_q[i]};
			// level, then resumed first, then arrival age, then creation
			if (cand[i] && (!best_vld || key < best_key)) begin
				best_vld = 1'b1;
				best_idx = 6'(i);
				best_key = key;
			end
		end
	end

	// age stamp wraps every 65536 cycles; requests stamped either side of a wrap may reorder
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			age_cnt_q <= 16'h0000;
		end else begin
			age_cnt_q <= age_cnt_q + 16'h0001;
		end
	end

	// ************************************************
	// pending flags
	// ************************************************
	logic dev_sample;

	// device conditions are only looked at when the scan ends
	assign dev_sample = scan_end_i && mode_run_i && !pf_q;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= '0;
			for (int i = 0; i < TPS_NUM_TASK; i++) begin
				stamp_q[i] <= 16'h0000;
			end
		end else if (long_resume) begin
			pend_q <= '0;
		end else begin
			for (int i = 0; i < TPS_NUM_TASK; i++) begin
				if (!cur_vld_q && best_vld && best_idx == 6'(i)) begin
					pend_q[i] <= 1'b0;
				end
				if (i < TPS_NUM_FIX) begin
					// duplicate while pending or running is dropped
					if (tmr.expire[i] && used_q[i] && !pend_q[i] &&
						!started_q[i]) begin
						pend_q[i] <= 1'b1;
						stamp_q[i] <= age_cnt_q;
					end
				end else if (dev_sample && dev_cond_i[i-TPS_NUM_FIX] &&
					used_q[i] && !pend_q[i] && !started_q[i]) begin
					pend_q[i] <= 1'b1;
					stamp_q[i] <= age_cnt_q;
				end
			end
			if (cur_vld_q && !task_done_i && best_vld &&
				best_key.prio < prio_q[cur_q]) begin
				pend_q[best_idx] <= 1'b0;
			end
		end
	end

	// ************************************************
	// running and suspended tasks
	// ************************************************
	logic preempt;

	// strictly more urgent only; equal level waits for completion
	assign preempt = cur_vld_q && !task_done_i && best_vld &&
		best_key.prio < prio_q[cur_q];

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			started_q <= '0;
			cur_vld_q <= 1'b0;
			cur_q <= 6'h00;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (cur_vld_q && task_done_i) begin
				started_q[cur_q] <= 1'b0;
				cur_vld_q <= 1'b0;
			end else if ((!cur_vld_q || preempt) && best_vld) begin
				// old task stays started, i.e. suspended
				started_q[best_idx] <= 1'b1;
				cur_vld_q <= 1'b1;
				cur_q <= best_idx;
				start_q <= !started_q[best_idx];
			end
		end
	end

	// ************************************************
	// cyclic task execution time
	// ************************************************
	logic fix_busy, fix_busy_q;
	logic [31:0] tenth_cnt_q;
	logic [15:0] tcur_q, tmax_q, tmin_q, tlast_q;

	assign fix_busy = |started_q[TPS_NUM_FIX-1:0];

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fix_busy_q <= 1'b0;
			tenth_cnt_q <= 32'h0000_0000;
			tcur_q <= 16'h0000;
		end else begin
			fix_busy_q <= fix_busy;
			if (fix_busy && !fix_busy_q) begin
				tenth_cnt_q <= 32'h0000_0000;
				tcur_q <= 16'h0000;
			end else if (tenth_cnt_q == 32'(TENTH_CYC - 1)) begin
				tenth_cnt_q <= 32'h0000_0000;
				if (tcur_q != 16'hffff) begin
					tcur_q <= tcur_q + 16'h0001;
				end
			end else begin
				tenth_cnt_q <= tenth_cnt_q + 32'h0000_0001;
			end
		end
	end

	// min starts at all ones: never executed
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tmax_q <= TPS_TMAX_RST;
			tmin_q <= TPS_TMIN_RST;
			tlast_q <= 16'h0000;
		end else if (fix_busy_q && !fix_busy) begin
			tlast_q <= tcur_q;
			if (tcur_q > tmax_q) begin
				tmax_q <= tcur_q;
			end
			if (tcur_q < tmin_q) begin
				tmin_q <= tcur_q;
			end
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	tps_vec_t dev_wait;

	assign dev_wait = (pend_q | started_q) &
		{{TPS_NUM_DEV{1'b1}}, {TPS_NUM_FIX{1'b0}}};
	assign run_vld_o = cur_vld_q;
	assign run_task_o = tps_idx_to_num(cur_q);
	assign run_start_o = start_q;
	// scan only with no task active and device tasks drained
	assign scan_run_o = mode_run_i && !pf_q && !cur_vld_q && !init_busy_i &&
		!(|dev_wait);
	assign run_allowed_o = allow_q;
	assign pending_o = pend_q;
	assign cyc_time_max_o = tmax_q;
	assign cyc_time_min_o = tmin_q;
	assign cyc_time_cur_o = tlast_q;

endmodule : tps_top
`default_nettype wire

/* tps_top_sva.sv */
// checker of the task priority scheduler port behaviour
`timescale 1ns/1ps
`default_nettype none
module tps_top_sva import tps_pkg::*; (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// watched inputs
	input wire logic init_busy_i,
	input wire logic task_run_block_cmd_i,
	input wire logic task_run_allow_cmd_i,
	input wire logic task_done_i,
	input wire logic mode_run_i,
	// watched outputs
	input wire logic run_vld_o,
	input wire logic [6:0] run_task_o,
	input wire logic run_start_o,
	input wire logic scan_run_o,
	input wire logic run_allowed_o,
	input wire logic [TPS_NUM_TASK-1:0] pending_o,
	input wire logic [15:0] cyc_time_max_o,
	input wire logic [15:0] cyc_time_min_o
);
	// ****************************************
	// port rules
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	scan_yield_a: assert property (run_vld_o |-> !scan_run_o)
		else $error("scan runs beside a task");
	scan_stop_a: assert property (!mode_run_i |-> !scan_run_o)
		else $error("scan runs outside run mode");
	done_free_a: assert property (task_done_i && run_vld_o |=> !run_vld_o)
		else $error("grant kept after done");
	block_hold_a: assert property (!run_allowed_o |=> !run_start_o)
		else $error("start while blocked");
	block_cmd_a: assert property (task_run_block_cmd_i |=> !run_allowed_o)
		else $error("block command not taken");
	allow_cmd_a: assert property (
		task_run_allow_cmd_i && !task_run_block_cmd_i |=> run_allowed_o)
		else $error("allow command not taken");
	init_hold_a: assert property (init_busy_i |=> !run_start_o)
		else $error("start during initialization");
	start_clear_a: assert property (run_start_o |-> run_vld_o &&
		!pending_o[{run_task_o[6], run_task_o[4:0]}])
		else $error("pending kept at start");
	task_range_a: assert property (run_vld_o |->
		run_task_o < 7'h20 || run_task_o inside {[7'h40:7'h5f]})
		else $error("granted number out of range");
	time_order_a: assert property (
		cyc_time_min_o != TPS_TMIN_RST |-> cyc_time_min_o <= cyc_time_max_o)
		else $error("minimum time above maximum");
	cover property (run_start_o && run_task_o[6]);
	cover property (run_vld_o && !run_start_o && $changed(run_task_o));
	cover property (!run_allowed_o && pending_o != '0);
endmodule : tps_top_sva
bind tps_top tps_top_sva u_sva (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
	.init_busy_i(init_busy_i), .task_run_block_cmd_i(task_run_block_cmd_i),
	.task_run_allow_cmd_i(task_run_allow_cmd_i), .task_done_i(task_done_i),
	.mode_run_i(mode_run_i), .run_vld_o(run_vld_o), .run_task_o(run_task_o),
	.run_start_o(run_start_o), .scan_run_o(scan_run_o),
	.run_allowed_o(run_allowed_o), .pending_o(pending_o),
	.cyc_time_max_o(cyc_time_max_o), .cyc_time_min_o(cyc_time_min_o));
`default_nettype wire
